// [hw/pinctl_map.vh]
`ifndef PINCTL_MAP_VH
`define PINCTL_MAP_VH

// register byte addresses on the wishbone slave
`define ADR_IRQ_CTRL    8'h00
`define ADR_WIN_SEL     8'h04
`define ADR_P2_FUNC     8'h08
`define ADR_PORT2_DIRECTION      8'h0c
`define ADR_P2_OUT      8'h10
`define ADR_IRQ_ENABLE  8'h14
`define ADR_PWR_CTRL    8'h18
`define ADR_STATUS      8'h1c
`define ADR_IRQ_PEND    8'h20

// ext_irq_control: bits 3:0 level mode, bits 7:4 active-high polarity
`define IRQ_LEVEL_LSB   0
`define IRQ_POL_LSB     4
// window select: bus-hold enable bit
`define WIN_HOLD_EN_BIT 7
// port2 bit positions of the shared pins
`define P2_PENDING_BUS_REQUEST_N_BIT     3
`define P2_HOLD_BIT     5
`define P2_HOLD_ACK_N_BIT     6
`define P2_HOLD_MASK    8'h68
// forced directions while hold is on: bits 3,6 drive, bit 5 listens
`define P2_HOLD_DIR     8'h48
// port2 function bits that route irq0/irq2 and irq1/irq3 to their pins
`define P2_IRQ_A_BIT    2
`define P2_IRQ_B_BIT    4
// power control codes
`define PWR_RUN         2'h0
`define PWR_IDLE        2'h1
`define PWR_STANDBY     2'h2
`define PWR_POWERDOWN   2'h3

// reset values
`define RST_IRQ_CTRL    8'h00
`define RST_WIN_SEL     8'h00
`define RST_P2          8'h00

`endif

// [hw/irq_pin_detect.v]
`timescale 1ns/10ps
`default_nettype none

// one external interrupt input: edge or level, selectable polarity
module irq_pin_detect
(
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire pin_i,
  input  wire level_mode_i,
  input  wire active_high_i,
  input  wire clear_i,
  output reg  pending_o,
  output wire asserted_o
);

  reg last;
  wire norm;

  assign norm       = pin_i ~^ active_high_i; // R2
  assign asserted_o = norm;

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      last      <= 1'b0;
      pending_o <= 1'b0;
    end
    else
    begin
      last <= norm;
      // set wins over a clear in the same cycle
      if (level_mode_i)
        pending_o <= norm; // R1
      else if (norm && !last)
        pending_o <= 1'b1; // R1
      else if (clear_i)
        pending_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [hw/bus_hold_fsm.v]
`timescale 1ns/10ps
`default_nettype none

// bus hold handshake: after the current cycle, release bus and ack in the same clock
module bus_hold_fsm
(
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire enable_i,
  input  wire hold_req_n_i,
  input  wire cycle_busy_i,
  input  wire cycle_pending_i,
  output reg  hold_ack_n_o,
  output reg  pending_bus_request_n_n_o,
  output reg  bus_float_o
);

  localparam ST_OWN  = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_HELD = 2'h2;

  reg [1:0] state;

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state        <= ST_OWN;
      hold_ack_n_o <= 1'b1;
      pending_bus_request_n_n_o     <= 1'b1;
      bus_float_o  <= 1'b0;
    end
    else
    begin
      case (state)
        ST_OWN:
        begin
          if (enable_i && !hold_req_n_i)
            state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (hold_req_n_i || !enable_i)
            state <= ST_OWN;
          else if (!cycle_busy_i) // R13
          begin
            state        <= ST_HELD;
            bus_float_o  <= 1'b1;
            hold_ack_n_o <= 1'b0; // R6
          end
        end
        ST_HELD:
        begin
          if (hold_req_n_i || !enable_i) // R13
          begin
            state        <= ST_OWN;
            bus_float_o  <= 1'b0;
            hold_ack_n_o <= 1'b1;
            pending_bus_request_n_n_o     <= 1'b1; // R12
          end
          else if (cycle_pending_i)
            pending_bus_request_n_n_o <= 1'b0; // R12
        end
        default:
          state <= ST_OWN;
      endcase
    end
  end

endmodule

`default_nettype wire

// [hw/ext_irq_wake_bus_hold_pins.v]
// Functional notes
// R1: each external interrupt edge or level
// R2: each interrupt polarity selectable
// R3: standby/powerdown wake on configured pin, even disabled
// R4: after wake, service if enabled else continue
// R5: idle wakes on any enabled interrupt
// R6: hold ack asserted once bus released
// R7: external master requests bus via hold request
// R8: window bit 7 dedicates shared port pins
// R9: pin reconfiguration ignored while hold enabled
// R10: fetch indicator high whole external fetch
// R11: fetch indicator low for other accesses
// R12: bus request asserted until hold removed
// R13: finish cycle before ack, reclaim after release
`timescale 1ns/10ps
`default_nettype none
`include "pinctl_map.vh"

module ext_irq_wake_bus_hold_pins
#(
  parameter NIRQ = 4
)
(
  input  wire            MCLK_I,
  input  wire            RST_B_I,
  // wishbone classic slave
  input  wire            WB_CYC_I,
  input  wire            WB_STB_I,
  input  wire            WB_WE_I,
  input  wire [7:0]      WB_ADR_I,
  input  wire [3:0]      WB_SEL_I,
  input  wire [31:0]     WB_DAT_I,
  output reg  [31:0]     WB_DAT_O,
  output reg             WB_ACK_O,
  // pins
  input  wire [NIRQ-1:0] EXT_IRQ_IN_I,
  input  wire            HOLD_REQ_N_I,
  output reg             HOLD_ACK_N_O,
  output reg             PENDING_BUS_REQUEST_N_O,
  // bus controller side
  input  wire            CYCLE_BUSY_I,
  input  wire            CYCLE_PENDING_I,
  input  wire            CYCLE_START_I,
  input  wire            CYCLE_END_I,
  input  wire            CYCLE_IS_FETCH_I,
  input  wire            CYCLE_IS_EXTERNAL_I,
  input  wire            OTHER_IRQ_I,
  output reg             BUS_FLOAT_O,
  output reg             FETCH_INDICATOR_O,
  // cpu side
  output reg             CPU_RUN_O,
  output reg             WAKE_SERVICE_O,
  output reg  [NIRQ-1:0] IRQ_REQ_O,
  output reg  [7:0]      P2_FUNC_O,
  output reg  [7:0]      PORT2_DIRECTION_O,
  output reg  [7:0]      P2_OUT_O
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0]      ext_irq_control;
  reg [7:0]      window_select_reg;
  reg [7:0]      port2_function_select;
  reg [7:0]      port2_direction;
  reg [7:0]      port2_output_data;
  reg [NIRQ-1:0] irq_enable;
  reg [1:0]      pwr_mode;
  reg [NIRQ-1:0] irq_clear;

  wire           wb_req;
  wire           wb_wr;
  wire           hold_en;
  wire [NIRQ-1:0] pend;
  wire [NIRQ-1:0] asserted;
  wire           hold_ack_n;
  wire           pending_bus_request_n_n;
  wire           bus_float;
  wire [7:0]     keep_mask;

  assign wb_req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr     = wb_req && WB_WE_I && WB_SEL_I[0];
  assign hold_en   = window_select_reg[`WIN_HOLD_EN_BIT]; // R8
  // pins owned by hold protocol keep their old configuration
  assign keep_mask = hold_en ? `P2_HOLD_MASK : 8'h00; // R9

  // ----------------------------------------
  // interrupt detectors
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NIRQ; g = g + 1)
    begin : irq_gen
      irq_pin_detect u_det
      (
        .clk_i        (MCLK_I),
        .rst_b_i      (RST_B_I),
        .pin_i        (EXT_IRQ_IN_I[g]),
        .level_mode_i (ext_irq_control[`IRQ_LEVEL_LSB + g]),
        .active_high_i(ext_irq_control[`IRQ_POL_LSB + g]),
        .clear_i      (irq_clear[g]),
        .pending_o    (pend[g]),
        .asserted_o   (asserted[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // bus hold
  // ----------------------------------------
  bus_hold_fsm u_hold
  (
    .clk_i          (MCLK_I),
    .rst_b_i        (RST_B_I),
    .enable_i       (hold_en),
    .hold_req_n_i   (HOLD_REQ_N_I), // R7
    .cycle_busy_i   (CYCLE_BUSY_I),
    .cycle_pending_i(CYCLE_PENDING_I),
    .hold_ack_n_o   (hold_ack_n),
    .pending_bus_request_n_n_o       (pending_bus_request_n_n),
    .bus_float_o    (bus_float)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ext_irq_control       <= `RST_IRQ_CTRL;
      window_select_reg     <= `RST_WIN_SEL;
      port2_function_select <= `RST_P2;
      port2_direction       <= `RST_P2;
      port2_output_data     <= `RST_P2;
      irq_enable            <= {NIRQ{1'b0}};
      irq_clear             <= {NIRQ{1'b0}};
    end
    else
    begin
      irq_clear <= {NIRQ{1'b0}};
      if (wb_wr)
      begin
        if (WB_ADR_I == `ADR_IRQ_CTRL)
          ext_irq_control <= WB_DAT_I[7:0]; // R1
        else if (WB_ADR_I == `ADR_WIN_SEL)
          window_select_reg <= WB_DAT_I[7:0];
        else if (WB_ADR_I == `ADR_P2_FUNC)
          port2_function_select <= (port2_function_select & keep_mask) | (WB_DAT_I[7:0] & ~keep_mask); // R9
        else if (WB_ADR_I == `ADR_PORT2_DIRECTION)
          port2_direction <= (port2_direction & keep_mask) | (WB_DAT_I[7:0] & ~keep_mask); // R9
        else if (WB_ADR_I == `ADR_P2_OUT)
          port2_output_data <= (port2_output_data & keep_mask) | (WB_DAT_I[7:0] & ~keep_mask); // R9
        else if (WB_ADR_I == `ADR_IRQ_ENABLE)
          irq_enable <= WB_DAT_I[NIRQ-1:0];
        else if (WB_ADR_I == `ADR_IRQ_PEND)
          irq_clear <= WB_DAT_I[NIRQ-1:0];
      end
    end
  end

  // ----------------------------------------
  // power modes and wake-up
  // ----------------------------------------
  wire wake_sb;
  wire wake_idle;

  // standby wake needs the pin in special-function mode, not enable
  assign wake_sb   = |(asserted & {port2_function_select[`P2_IRQ_B_BIT], port2_function_select[`P2_IRQ_A_BIT],
                                    port2_function_select[`P2_IRQ_B_BIT], port2_function_select[`P2_IRQ_A_BIT]}); // R3
  assign wake_idle = (|(pend & irq_enable)) || OTHER_IRQ_I; // R5

  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      pwr_mode       <= `PWR_RUN;
      WAKE_SERVICE_O <= 1'b0;
    end
    else
    begin
      WAKE_SERVICE_O <= 1'b0;
      if (wb_wr && WB_ADR_I == `ADR_PWR_CTRL)
        pwr_mode <= WB_DAT_I[1:0];
      else if (pwr_mode == `PWR_IDLE && wake_idle)
      begin
        pwr_mode       <= `PWR_RUN; // R5
        WAKE_SERVICE_O <= 1'b1;
      end
      else if ((pwr_mode == `PWR_STANDBY || pwr_mode == `PWR_POWERDOWN) && wake_sb)
      begin
        pwr_mode       <= `PWR_RUN; // R3
        WAKE_SERVICE_O <= |(asserted & irq_enable); // R4
      end
    end
  end

  // ----------------------------------------
  // fetch indicator
  // ----------------------------------------
  reg fetch_active;
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      fetch_active <= 1'b0;
    else if (CYCLE_START_I)
      fetch_active <= CYCLE_IS_FETCH_I && CYCLE_IS_EXTERNAL_I; // R10 R11
    else if (CYCLE_END_I)
      fetch_active <= 1'b0; // R11
  end

  // ----------------------------------------
  // outputs and read mux
  // ----------------------------------------
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      WB_ACK_O                <= 1'b0;
      WB_DAT_O                <= 32'h0000_0000;
      HOLD_ACK_N_O            <= 1'b1;
      PENDING_BUS_REQUEST_N_O <= 1'b1;
      BUS_FLOAT_O             <= 1'b0;
      FETCH_INDICATOR_O       <= 1'b0;
      CPU_RUN_O               <= 1'b1;
      IRQ_REQ_O               <= {NIRQ{1'b0}};
      P2_FUNC_O               <= `RST_P2;
      PORT2_DIRECTION_O                <= `RST_P2;
      P2_OUT_O                <= `RST_P2;
    end
    else
    begin
      WB_ACK_O                <= wb_req;
      HOLD_ACK_N_O            <= hold_ack_n; // R6
      PENDING_BUS_REQUEST_N_O <= pending_bus_request_n_n; // R12
      BUS_FLOAT_O             <= bus_float;
      FETCH_INDICATOR_O       <= fetch_active; // R10
      CPU_RUN_O               <= (pwr_mode == `PWR_RUN);
      IRQ_REQ_O               <= pend & irq_enable;
      // shared pins forced to hold functions while enabled
      P2_FUNC_O <= hold_en ? (port2_function_select | `P2_HOLD_MASK) : port2_function_select; // R8
      PORT2_DIRECTION_O  <= hold_en ? ((port2_direction & ~`P2_HOLD_MASK) | `P2_HOLD_DIR) : port2_direction; // R8
      P2_OUT_O  <= port2_output_data;
      if (wb_req && !WB_WE_I)
      begin
        if (WB_ADR_I == `ADR_IRQ_CTRL)
          WB_DAT_O <= {24'h000000, ext_irq_control};
        else if (WB_ADR_I == `ADR_WIN_SEL)
          WB_DAT_O <= {24'h000000, window_select_reg};
        else if (WB_ADR_I == `ADR_P2_FUNC)
          WB_DAT_O <= {24'h000000, port2_function_select};
        else if (WB_ADR_I == `ADR_PORT2_DIRECTION)
          WB_DAT_O <= {24'h000000, port2_direction};
        else if (WB_ADR_I == `ADR_P2_OUT)
          WB_DAT_O <= {24'h000000, port2_output_data};
        else if (WB_ADR_I == `ADR_IRQ_ENABLE)
          WB_DAT_O <= {{(32-NIRQ){1'b0}}, irq_enable};
        else if (WB_ADR_I == `ADR_PWR_CTRL)
          WB_DAT_O <= {30'h00000000, pwr_mode};
        else if (WB_ADR_I == `ADR_STATUS)
          WB_DAT_O <= {28'h0000000, fetch_active, bus_float, ~pending_bus_request_n_n, ~hold_ack_n};
        else if (WB_ADR_I == `ADR_IRQ_PEND)
          WB_DAT_O <= {{(32-NIRQ){1'b0}}, pend};
        else
          WB_DAT_O <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// [bench/hold_master_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// external bus master and interrupt sources
// ----------------------------------------
module hold_master_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       want_bus_i,
  input  wire logic [3:0] irq_drive_i,
  output var  logic       hold_req_n_o,
  output var  logic [3:0] irq_o
);
  // registered so requests only move right after an edge
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hold_req_n_o <= 1'b1;
      irq_o        <= 4'h0;
    end
    else
    begin
      hold_req_n_o <= !want_bus_i;
      irq_o        <= irq_drive_i;
    end
  end
endmodule
`default_nettype wire

// [bench/ext_irq_wake_bus_hold_pins_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port relation checks
// ----------------------------------------
module ext_irq_wake_bus_hold_pins_checker
(
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic HOLD_REQ_N_I,
  input wire logic HOLD_ACK_N_O,
  input wire logic PENDING_BUS_REQUEST_N_O,
  input wire logic CYCLE_START_I,
  input wire logic CYCLE_IS_FETCH_I,
  input wire logic CYCLE_IS_EXTERNAL_I,
  input wire logic BUS_FLOAT_O,
  input wire logic FETCH_INDICATOR_O,
  input wire logic CPU_RUN_O,
  input wire logic WAKE_SERVICE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("wishbone ack missing");
  a_hold_float: assert property ($fell(HOLD_ACK_N_O) |-> BUS_FLOAT_O)
    else $error("hold ack without bus released");
  a_hold_cause: assert property ($fell(HOLD_ACK_N_O) |-> $past(!HOLD_REQ_N_I, 2))
    else $error("hold ack without request");
  a_hold_drop: assert property ($rose(HOLD_REQ_N_I) && !HOLD_ACK_N_O |-> ##[1:2] HOLD_ACK_N_O)
    else $error("hold ack not removed");
  a_pending_bus_request_n_keep: assert property (!PENDING_BUS_REQUEST_N_O && !HOLD_REQ_N_I |=> !PENDING_BUS_REQUEST_N_O)
    else $error("bus request dropped during hold");
  a_pending_bus_request_n_held: assert property ($fell(PENDING_BUS_REQUEST_N_O) |-> !HOLD_ACK_N_O)
    else $error("bus request outside hold");
  a_fetch_rise: assert property (CYCLE_START_I && CYCLE_IS_FETCH_I && CYCLE_IS_EXTERNAL_I
    |-> ##[1:2] FETCH_INDICATOR_O)
    else $error("fetch indicator late");
  a_fetch_quiet: assert property (CYCLE_START_I && !(CYCLE_IS_FETCH_I && CYCLE_IS_EXTERNAL_I)
    && !FETCH_INDICATOR_O |=> !FETCH_INDICATOR_O [*2])
    else $error("fetch indicator on other cycle");
  a_wake_pulse: assert property (WAKE_SERVICE_O |-> ##[0:1] CPU_RUN_O ##1 !WAKE_SERVICE_O)
    else $error("service wake malformed");
endmodule
bind ext_irq_wake_bus_hold_pins ext_irq_wake_bus_hold_pins_checker chk (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .HOLD_REQ_N_I(HOLD_REQ_N_I),
  .HOLD_ACK_N_O(HOLD_ACK_N_O), .PENDING_BUS_REQUEST_N_O(PENDING_BUS_REQUEST_N_O),
  .CYCLE_START_I(CYCLE_START_I), .CYCLE_IS_FETCH_I(CYCLE_IS_FETCH_I),
  .CYCLE_IS_EXTERNAL_I(CYCLE_IS_EXTERNAL_I), .BUS_FLOAT_O(BUS_FLOAT_O),
  .FETCH_INDICATOR_O(FETCH_INDICATOR_O), .CPU_RUN_O(CPU_RUN_O), .WAKE_SERVICE_O(WAKE_SERVICE_O));
`default_nettype wire

// [bench/ext_irq_wake_bus_hold_pins_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pinctl_map.vh"
module ext_irq_wake_bus_hold_pins_test;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, want = 0, busy = 0, pend = 0;
  logic st = 0, isf = 0, ise = 0, other = 0, hreq_n, hack_n, pending_bus_request_n_n, ack, flt, fet, run, wsv;
  logic [7:0] adr = 0, p2f, p2d;
  logic [31:0] dat = 0, rdat;
  logic [3:0] irq = 0, pins, req;
  int mismatches = 0, num_checks = 0, wakes = 0, w0, m;
  ext_irq_wake_bus_hold_pins dut (.MCLK_I(clk), .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .EXT_IRQ_IN_I(pins), .HOLD_REQ_N_I(hreq_n), .HOLD_ACK_N_O(hack_n), .PENDING_BUS_REQUEST_N_O(pending_bus_request_n_n),
    .CYCLE_BUSY_I(busy), .CYCLE_PENDING_I(pend), .CYCLE_START_I(st), .CYCLE_END_I(!st && !isf),
    .CYCLE_IS_FETCH_I(isf), .CYCLE_IS_EXTERNAL_I(ise), .OTHER_IRQ_I(other), .BUS_FLOAT_O(flt),
    .FETCH_INDICATOR_O(fet), .CPU_RUN_O(run), .WAKE_SERVICE_O(wsv), .IRQ_REQ_O(req), .P2_FUNC_O(p2f),
    .PORT2_DIRECTION_O(p2d), .P2_OUT_O());
  hold_master_model far (.clk_i(clk), .rst_b_i(rst_b), .want_bus_i(want), .irq_drive_i(irq),
    .hold_req_n_o(hreq_n), .irq_o(pins));
  initial forever #5 clk = !clk;
  always @(posedge clk) if (wsv === 1'b1) wakes <= wakes + 1;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude;
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waits for ack without assuming its latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      mismatches++;
      conclude;
    end
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(0, a, 8'h0);
    chk("read", e, rdat[7:0]);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic f, input logic e);
    st <= 1; isf <= f; ise <= e; tick(1);
    st <= 0; tick(4);
    chk("fetch", {7'h0, f && e}, {7'h0, fet});
    isf <= 0; tick(4);
    chk("fetch end", 8'h0, {7'h0, fet});
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    tick(3);
    rst_b <= 1; tick(1);
    rd(`ADR_IRQ_CTRL, `RST_IRQ_CTRL);
    rd(`ADR_WIN_SEL, `RST_WIN_SEL);
    rd(8'hfc, 8'h00);
    for (m = 0; m < 4; m++)
    begin
      irq <= {4{!m[1]}}; tick(2);
      wb(1, `ADR_IRQ_CTRL, {{4{m[1]}}, {4{m[0]}}});
      wb(1, `ADR_IRQ_ENABLE, 8'h0f);
      wb(1, `ADR_IRQ_PEND, 8'h0f); tick(3);
      chk("irq idle", 8'h0, {4'h0, req});
      irq <= {4{m[1]}}; tick(5);
      chk("irq active", 8'h0f, {4'h0, req});
      irq <= {4{!m[1]}}; tick(5);
      chk("irq gone", m[0] ? 8'h0 : 8'h0f, {4'h0, req});
    end
    // shared pins: stored value keeps while hold is on, writes to them ignored
    wb(1, `ADR_P2_FUNC, 8'hff);
    wb(1, `ADR_WIN_SEL, 8'h80);
    wb(1, `ADR_P2_FUNC, 8'h00); tick(2);
    chk("dir forced", 8'h01, {7'h0, p2d[3] === p2d[6] && p2d[5] !== p2d[3]});
    chk("func forced", `P2_HOLD_MASK, p2f);
    busy <= 1; want <= 1; tick(8);
    chk("ack early", 8'h01, {7'h0, hack_n});
    busy <= 0; tick(6);
    chk("ack", 8'h00, {6'h0, hack_n, !flt});
    pend <= 1; tick(4);
    pend <= 0; tick(4);
    chk("pending_bus_request_n", 8'h00, {7'h0, pending_bus_request_n_n});
    want <= 0; tick(5);
    chk("release", 8'h03, {6'h0, hack_n, pending_bus_request_n_n});
    wb(1, `ADR_WIN_SEL, 8'h00);
    rd(`ADR_P2_FUNC, `P2_HOLD_MASK);
    for (m = 0; m < 4; m++) bus(m[0], m[1]);
    // standby wakes on a disabled pin with no service routine; powerdown on an enabled pin runs it; idle ignores a disabled pin
    irq <= 0;
    wb(1, `ADR_P2_FUNC, 8'h04);
    wb(1, `ADR_IRQ_CTRL, 8'hf1);
    wb(1, `ADR_IRQ_ENABLE, 8'h00);
    w0 = wakes;
    wb(1, `ADR_PWR_CTRL, {6'h0, `PWR_STANDBY}); tick(3);
    chk("sleep", 8'h0, {7'h0, run});
    irq <= 1; tick(6);
    chk("standby wake", 8'h01, {7'h0, run});
    chk("no service", 8'h0, 8'(wakes - w0));
    irq <= 0;
    wb(1, `ADR_IRQ_ENABLE, 8'h01);
    wb(1, `ADR_PWR_CTRL, {6'h0, `PWR_POWERDOWN}); tick(3);
    irq <= 1; tick(6);
    chk("service", 8'h01, 8'(wakes - w0));
    irq <= 0;
    wb(1, `ADR_IRQ_ENABLE, 8'h00);
    wb(1, `ADR_PWR_CTRL, {6'h0, `PWR_IDLE});
    irq <= 1; tick(6);
    chk("idle stays", 8'h0, {7'h0, run});
    other <= 1; tick(4);
    chk("idle wake", 8'h01, {7'h0, run});
    conclude;
  end
  initial
  begin
    tick(5000);
    mismatches++;
    conclude;
  end
endmodule
`default_nettype wire
